/* File: rtl/aofc_conv.sv */
// Converter end: pipeline, format coding and output drive
`timescale 1ns/10ps
`default_nettype none
module aofc_conv #(
  parameter int unsigned LATENCY = aofc_pkg::LATENCY_CYC,
  parameter int unsigned INIT    = aofc_pkg::INIT_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Sampled code, offset binary, from the analog core
  input  wire aofc_pkg::aofc_word_t code_i,
  // Status
  output logic                     valid_o,
  // Link
  aofc_if.conv                     link
);
  import aofc_pkg::*;

  // ==========================================
  // Elaboration checks
  if (LATENCY < 1) begin : g_bad_latency
    $error("aofc_conv: LATENCY must be at least one");
  end
  if (INIT >= (1 << CNT_W)) begin : g_bad_init
    $error("aofc_conv: INIT does not fit the init counter");
  end

  // ==========================================
  // Falling edge detect of sample clock
  logic sclk_ff;
  logic nxt_sclk;
  logic fall;
  always_comb begin
    nxt_sclk = link.sample_clk;
    fall     = sclk_ff & ~link.sample_clk;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_ff <= 1'b0;
    end else begin
      sclk_ff <= nxt_sclk;
    end
  end

  // ==========================================
  // Latency pipeline, one stage per sample clock
  // Tap 0 is the fresh code, tap LATENCY the oldest stage
  wire aofc_word_t tap [LATENCY+1];
  assign tap[0] = code_i;
  for (genvar g = 0; g < LATENCY; g++) begin : g_stage
    aofc_word_t stage_ff;
    aofc_word_t nxt_stage;
    always_comb begin
      nxt_stage = stage_ff;
      if (fall) begin
        nxt_stage = tap[g];
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stage_ff <= CODE_ZERO;
      end else begin
        stage_ff <= nxt_stage;
      end
    end
    assign tap[g+1] = stage_ff;
  end

  // ==========================================
  // Init counter, output register and drive
  logic [CNT_W-1:0] init_ff;
  logic [CNT_W-1:0] nxt_init;
  aofc_word_t       data_ff;
  aofc_word_t       nxt_data;
  logic             oe_n_ff;
  logic             nxt_oe_n;
  logic             valid_ff;
  logic             nxt_valid;
  always_comb begin
    nxt_init  = init_ff;
    nxt_data  = data_ff;
    nxt_valid = valid_ff;
    if (fall && init_ff != CNT_W'(INIT)) begin
      nxt_init = init_ff + CNT_ONE;
    end
    if (fall) begin
      if (link.format_select == FMT_TWOS_COMP) begin
        nxt_data = tap[LATENCY] ^ MSB_MASK;
      end else begin
        nxt_data = tap[LATENCY];
      end
      nxt_valid = (init_ff == CNT_W'(INIT));
    end
    nxt_oe_n = (link.drive_n == DRIVE_OFF_N) ? DRIVE_OFF_N : DRIVE_ON_N;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_ff  <= CNT_ZERO;
      data_ff  <= CODE_ZERO;
      oe_n_ff  <= DRIVE_OFF_N;
      valid_ff <= 1'b0;
    end else begin
      init_ff  <= nxt_init;
      data_ff  <= nxt_data;
      oe_n_ff  <= nxt_oe_n;
      valid_ff <= nxt_valid;
    end
  end

  assign link.data_out  = data_ff;
  assign link.data_oe_n = oe_n_ff;
  assign valid_o        = valid_ff;
endmodule
`default_nettype wire

/* File: rtl/aofc_pkg.sv */
// Package: shared constants and types for the converter output format link
package aofc_pkg;
  localparam int unsigned SAMPLE_W        = 10;
  localparam int unsigned LATENCY_CYC     = 7;
  localparam int unsigned INIT_CYC        = 20;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned MIN_RATE_KSPS   = 1000;
  localparam int unsigned DIV_W           = 8;
  localparam int unsigned CNT_W           = 6;
  localparam int unsigned MSB_POS         = SAMPLE_W - 1;
  localparam logic        FMT_OFFSET_BIN  = 1'b0;
  localparam logic        FMT_TWOS_COMP   = 1'b1;
  localparam logic        DRIVE_ON_N      = 1'b0;
  localparam logic        DRIVE_OFF_N     = 1'b1;
  localparam logic [SAMPLE_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [SAMPLE_W-1:0] MSB_MASK  = 10'h200;
  localparam logic [CNT_W-1:0]    CNT_ZERO  = 6'h00;
  localparam logic [CNT_W-1:0]    CNT_ONE   = 6'h01;
  typedef logic [SAMPLE_W-1:0] aofc_word_t;
endpackage

/* File: rtl/aofc_if.sv */
// Interface: parallel sample bus between converter and capture logic
`timescale 1ns/10ps
`default_nettype none
interface aofc_if;
  import aofc_pkg::*;
  logic       sample_clk;
  aofc_word_t data_out;
  logic       data_oe_n;
  logic       format_select;
  logic       drive_n;
  aofc_word_t data;
  // Bus level, float modeled as held zero
  assign data = (data_oe_n == DRIVE_ON_N) ? data_out : CODE_ZERO;
  modport conv (
    input  sample_clk,
    input  format_select,
    input  drive_n,
    output data_out,
    output data_oe_n
  );
  modport capt (
    output sample_clk,
    output format_select,
    output drive_n,
    input  data,
    input  data_oe_n
  );
endinterface
`default_nettype wire

/* File: rtl/aofc_capt.sv */
// Capture end: sample clock divider, controls and word capture
`timescale 1ns/10ps
`default_nettype none
module aofc_capt #(
  parameter int unsigned HALF_DIV = 4,
  parameter int unsigned DISCARD  = aofc_pkg::INIT_CYC + aofc_pkg::LATENCY_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // User controls
  input  wire logic                twos_comp_i,
  input  wire logic                enable_i,
  // Captured words
  output aofc_pkg::aofc_word_t     word_o,
  output logic                     word_vld_o,
  // Link
  aofc_if.capt                     link
);
  import aofc_pkg::*;

  // Sample rate must stay above 1 MSPS
  localparam int unsigned MAX_HALF = (CLK_MHZ * 1000) / (2 * MIN_RATE_KSPS);
  if (HALF_DIV < 1 || HALF_DIV >= MAX_HALF || HALF_DIV >= (1 << DIV_W)) begin : g_bad_div
    $error("aofc_capt: HALF_DIV out of range");
  end
  if (DISCARD < INIT_CYC + LATENCY_CYC || DISCARD >= (1 << CNT_W)) begin : g_bad_discard
    $error("aofc_capt: DISCARD out of range");
  end

  // ==========================================
  // Balanced divider for the sample clock
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic             sclk_ff;
  logic             nxt_sclk;
  logic             fmt_ff;
  logic             nxt_fmt;
  logic             drv_ff;
  logic             nxt_drv;
  logic             rise;
  always_comb begin
    rise     = 1'b0;
    nxt_div  = div_ff + 8'h01;
    nxt_sclk = sclk_ff;
    if (div_ff == DIV_W'(HALF_DIV - 1)) begin
      nxt_div  = 8'h00;
      nxt_sclk = ~sclk_ff;
      rise     = ~sclk_ff;
    end
    nxt_fmt = twos_comp_i;
    nxt_drv = enable_i ? DRIVE_ON_N : DRIVE_OFF_N;
  end

  // ==========================================
  // Word capture after discard period
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  aofc_word_t       word_ff;
  aofc_word_t       nxt_word;
  logic             vld_ff;
  logic             nxt_vld;
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_word = word_ff;
    nxt_vld  = 1'b0;
    if (rise) begin
      if (cnt_ff != CNT_W'(DISCARD)) begin
        nxt_cnt = cnt_ff + CNT_ONE;
      end else if (link.data_oe_n == DRIVE_ON_N) begin
        nxt_word = link.data;
        nxt_vld  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= 8'h00;
      sclk_ff <= 1'b0;
      fmt_ff  <= FMT_OFFSET_BIN;
      drv_ff  <= DRIVE_OFF_N;
      cnt_ff  <= CNT_ZERO;
      word_ff <= CODE_ZERO;
      vld_ff  <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      sclk_ff <= nxt_sclk;
      fmt_ff  <= nxt_fmt;
      drv_ff  <= nxt_drv;
      cnt_ff  <= nxt_cnt;
      word_ff <= nxt_word;
      vld_ff  <= nxt_vld;
    end
  end

  assign link.sample_clk    = sclk_ff;
  assign link.format_select = fmt_ff;
  assign link.drive_n       = drv_ff;
  assign word_o             = word_ff;
  assign word_vld_o         = vld_ff;
endmodule
`default_nettype wire

/* File: dv/aofc_link_assertions.sv */
// Checker: timing and drive relations on the converter link
`timescale 1ns/10ps
`default_nettype none
module aofc_link_chk (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Link
  input wire logic                 sample_clk,
  input wire logic                 drive_n,
  input wire logic                 data_oe_n,
  input wire aofc_pkg::aofc_word_t data_out,
  input wire aofc_pkg::aofc_word_t data
);
  import aofc_pkg::*;
  default clocking dclk @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Assertions
  a_oe_follows_drive: assert property (data_oe_n == $past(drive_n))
    else $error("output enable does not follow drive request");
  a_float_bus_zero: assert property (data_oe_n |-> data == CODE_ZERO)
    else $error("bus carries data while floated");
  a_out_after_fall: assert property ($changed(data_out) |-> !$past(sample_clk) &&
    ($past(sample_clk, 2) || $past(sample_clk, 3)))
    else $error("output word changed away from a sample clock fall");
  a_sclk_high_half: assert property ($rose(sample_clk) |-> sample_clk [*4] ##1 !sample_clk)
    else $error("sample clock high time wrong");
  a_sclk_low_half: assert property ($fell(sample_clk) |-> !sample_clk [*4] ##1 sample_clk)
    else $error("sample clock low time wrong");
  a_word_per_sample: assert property ($changed(data_out) |=> $stable(data_out) [*6])
    else $error("output word changed twice in one sample period");
  // ==========================================================
  // Coverage
  c_drive_on: cover property ($fell(data_oe_n));
  c_drive_off: cover property ($rose(data_oe_n));
  c_msb_word: cover property ($changed(data_out) && data_out[MSB_POS]);
endmodule
`default_nettype wire

/* File: dv/adc_output_format_control_test.sv */
// Testbench: both link ends joined, user sides driven and checked
`timescale 1ns/10ps
`default_nettype none
module adc_output_format_control_test;
  import aofc_pkg::*;
  logic       clk_i;
  logic       rst_i;
  logic       twos_comp_i;
  logic       enable_i;
  logic       valid_o;
  logic       word_vld_o;
  aofc_word_t code_i;
  aofc_word_t word_o;
  aofc_word_t got;
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  aofc_if link_if ();
  aofc_conv aofc_conv_inst (.clk_i(clk_i), .rst_i(rst_i), .code_i(code_i), .valid_o(valid_o),
    .link(link_if.conv));
  aofc_capt aofc_capt_inst (.clk_i(clk_i), .rst_i(rst_i), .twos_comp_i(twos_comp_i),
    .enable_i(enable_i), .word_o(word_o), .word_vld_o(word_vld_o), .link(link_if.capt));
  aofc_link_chk aofc_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sample_clk(link_if.sample_clk), .drive_n(link_if.drive_n),
    .data_oe_n(link_if.data_oe_n), .data_out(link_if.data_out), .data(link_if.data));
  // ==========================================================
  // Shared tasks
  task automatic check(input aofc_word_t act, input aofc_word_t exp, input string msg);
    compares++;
    if (act !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, act, exp);
    end
  endtask
  task automatic next_word(output aofc_word_t w);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (word_vld_o !== 1'h1 && n < 40);
    check(n < 40, 1'h1, "no captured word");
    w = word_o;
  endtask
  task automatic summarize;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_init;
    int n;
    n = 0;
    while (word_vld_o !== 1'h1 && n < 300) begin
      @(negedge clk_i);
      n++;
      if (n == 150) check(valid_o, 1'h0, "valid too early");
    end
    check(n > 208 && n < 232, 1'h1, "first word time");
    check(valid_o, 1'h1, "valid after init");
  endtask
  task automatic t_latency(input aofc_word_t a, input aofc_word_t b);
    code_i = a;
    repeat (9) next_word(got);
    check(got, a, "steady word");
    @(posedge link_if.sample_clk);
    @(negedge clk_i);
    code_i = b;
    repeat (7) begin
      next_word(got);
      check(got, a, "word changed early");
    end
    next_word(got);
    check(got, b, "word not changed");
  endtask
  task automatic t_codes;
    aofc_word_t tbl [6] = '{10'h3FF, 10'h3FE, 10'h200, 10'h1FF, 10'h001, 10'h000};
    for (int f = 0; f < 2; f++) begin
      twos_comp_i = f[0];
      foreach (tbl[i]) begin
        code_i = tbl[i];
        repeat (10) next_word(got);
        check(got, tbl[i] ^ (f[0] ? MSB_MASK : CODE_ZERO), "coded word");
      end
    end
  endtask
  task automatic t_drive_off;
    enable_i = 1'h0;
    repeat (4) @(negedge clk_i);
    check(link_if.data_oe_n, 1'h1, "bus not floated");
    repeat (40) begin
      @(negedge clk_i);
      check(word_vld_o, 1'h0, "word while floated");
    end
    enable_i = 1'h1;
    repeat (4) @(negedge clk_i);
    check(link_if.data_oe_n, 1'h0, "bus not driven");
    next_word(got);
    check(got, CODE_ZERO ^ MSB_MASK, "word after drive on");
  endtask
  // ==========================================================
  // Clock, timeout and main sequence
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    rst_i = 1'h1;
    twos_comp_i = 1'h0;
    enable_i = 1'h1;
    code_i = 10'h155;
    repeat (3) @(negedge clk_i);
    rst_i = 1'h0;
    t_init();
    t_latency(10'h2AA, 10'h0F0);
    t_codes();
    t_drive_off();
    summarize();
  end
endmodule
`default_nettype wire
